/* hw/rps_map.svh */
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH

////////////////////////////////////////////////////////////////////////////
// Clock
`define RPS_CLK_HZ 10000000
`define RPS_CLK_PERIOD_NS 100
`define RPS_CYC_PER_MS (`RPS_CLK_HZ / 1000)
`define RPS_CYC_PER_US (`RPS_CLK_HZ / 1000000)

////////////////////////////////////////////////////////////////////////////
// Reset input qualification times
`define RPS_FAST_MIN_NS 200
`define RPS_FAST_REJECT_NS 50
`define RPS_FAST_CYC (`RPS_FAST_MIN_NS / `RPS_CLK_PERIOD_NS)
`define RPS_SLOW_MIN_MS 100
`define RPS_SLOW_REJECT_MS 20
`define RPS_SLOW_CYC (`RPS_SLOW_REJECT_MS * `RPS_CYC_PER_MS)

////////////////////////////////////////////////////////////////////////////
// Deselect hold times
`define RPS_TREC_MID_MS 96
`define RPS_TREC_DEF_MS 40
`define RPS_TREC_SHORT_US 50
`define RPS_TREC_MID_CYC (`RPS_TREC_MID_MS * `RPS_CYC_PER_MS)
`define RPS_TREC_DEF_CYC (`RPS_TREC_DEF_MS * `RPS_CYC_PER_MS)
`define RPS_TREC_SHORT_CYC (`RPS_TREC_SHORT_US * `RPS_CYC_PER_US)

////////////////////////////////////////////////////////////////////////////
// Battery test period
`define RPS_BAT_PERIOD_H 24
`define RPS_BAT_CNT_W 40
`define RPS_BAT_PERIOD_CYC (64'd`RPS_BAT_PERIOD_H * 64'd3600 * 64'd`RPS_CLK_HZ)

////////////////////////////////////////////////////////////////////////////
// Register offsets
`define RPS_ADDR_STOP 6'h01
`define RPS_ADDR_CENT 6'h03
`define RPS_ADDR_TREC 6'h04
`define RPS_ADDR_CTRL 6'h08
`define RPS_ADDR_WDOG 6'h09
`define RPS_ADDR_ALRM 6'h0A
`define RPS_ADDR_HALT 6'h0C
`define RPS_ADDR_FLAG 6'h0F

////////////////////////////////////////////////////////////////////////////
// Field positions
`define RPS_BIT_ST 7
`define RPS_BIT_CEB 7
`define RPS_BIT_CB 6
`define RPS_BIT_TR 7
`define RPS_BIT_OUT 7
`define RPS_BIT_FT 6
`define RPS_BIT_AFE 7
`define RPS_BIT_SQUARE_WAVE_ENABLE 6
`define RPS_BIT_ABE 5
`define RPS_BIT_HT 6
`define RPS_BIT_BL 4

////////////////////////////////////////////////////////////////////////////
// Values at first power application
`define RPS_INIT_ST 1'h1
`define RPS_INIT_OUT 1'h1
`define RPS_INIT_HT 1'h1
`define RPS_INIT_TR 1'h0
`define RPS_INIT_WDOG 8'h00

`endif

/* hw/rps_pkg.sv */
`include "rps_map.svh"

package rps_pkg;

  typedef enum logic [1:0] {
    PS_BACKUP,
    PS_RECOVER,
    PS_RUN
  } rps_pwr_state_t;

  typedef struct packed {
    logic sup_meta;
    logic sup_sync;
    logic sns_meta;
    logic sns_sync;
    logic bat_meta;
    logic bat_sync;
    rps_pwr_state_t pwr;
    logic [`RPS_BAT_CNT_W-1:0] bat_cnt;
    logic rst_n;
    logic power_fail_flag_pin;
    logic irq_oe;
    logic wr_rej;
    logic [7:0] rd_data;
    logic ceb;
    logic cb;
    logic tr;
    logic st;
    logic ht;
    logic out;
    logic ft;
    logic afe;
    logic abe;
    logic square_wave_enable;
    logic [7:0] wd;
    logic bl;
  } rps_top_state_t;

endpackage : rps_pkg

/* hw/rps_hold_if.sv */
interface rps_hold_if #(
  parameter int unsigned W = 20
);
  logic cause;
  logic [W-1:0] len;
  logic busy;

  modport timer(input cause, input len, output busy);
  modport user(output cause, output len, input busy);
endinterface : rps_hold_if

/* hw/rps_glitch_filter.sv */
module rps_glitch_filter #(
  parameter int unsigned CNT_W = 20,
  parameter int unsigned MIN_CYC = 2
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Pin and qualified request
  input wire logic pin_n_in,
  output logic req_out
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic [CNT_W-1:0] cnt;
    logic req;
  } rps_filt_state_t;

  rps_filt_state_t s_q;
  rps_filt_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Low must persist MIN_CYC samples; shorter pulses never reach req
  always_comb begin
    s_d = s_q;
    s_d.meta = pin_n_in;
    s_d.sync = s_q.meta;
    if (s_q.sync) begin
      s_d.cnt = '0;
      s_d.req = 1'b0;
    end else if (s_q.cnt >= CNT_W'(MIN_CYC - 1)) begin
      s_d.req = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.meta <= 1'b1;
      s_q.sync <= 1'b1;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign req_out = s_q.req;

endmodule : rps_glitch_filter

/* hw/rps_hold_timer.sv */
module rps_hold_timer #(
  parameter int unsigned W = 20
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Hold request and status
  rps_hold_if.timer hold
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
  } rps_hold_state_t;

  rps_hold_state_t s_q;
  rps_hold_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // A new cause reloads, so the last request sets the end
  always_comb begin
    s_d = s_q;
    if (hold.cause) begin
      s_d.cnt = hold.len;
      s_d.busy = 1'b1;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
      s_d.busy = 1'b1;
    end else begin
      s_d.busy = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.busy <= 1'b1;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign hold.busy = s_q.busy;

endmodule : rps_hold_timer

/* hw/rps_supervisor.sv */
// How it works
// (R1) Two reset inputs each give a full reset
// (R2) Fast input: 200ns guaranteed, under 50ns ignored
// (R3) Slow input: 100ms guaranteed, under 20ms ignored
// (R4) Reset held one hold time after input release
// (R5) Running: flag low while sense below threshold
// (R6) Back-up: comparator off, flag held low
// (R7) Recovery: flag forced high, then follows sense
// (R8) Century flag toggles at rollover when enabled
// (R9) Output mode: pin shows control output bit
// (R10) Shared interrupt pin only pulls low
// (R11) Battery tested at power-up and daily
// (R12) Failed test sets battery low flag
// (R13) Flag clears only on a passing test
// (R14) No battery tests during back-up
// (R15) Select bit chooses deselect hold time
// (R16) Hold time from select and oscillator stop
// (R17) Host writes refused during recovery hold
// (R18) First power: listed bits cleared or set
// (R19) Later power-up: keep some, reset others
// (R20) Supply loss pulls reset, held after return
// (R21) Reset combines all causes, latest ends
`include "rps_map.svh"

module rps_supervisor #(
  parameter int unsigned CNT_W = 20,
  parameter int unsigned SLOW_CYC = `RPS_SLOW_CYC,
  parameter int unsigned TREC_MID_CYC = `RPS_TREC_MID_CYC,
  parameter int unsigned TREC_DEF_CYC = `RPS_TREC_DEF_CYC,
  parameter logic [`RPS_BAT_CNT_W-1:0] BAT_PERIOD_CYC =
    `RPS_BAT_CNT_W'(`RPS_BAT_PERIOD_CYC)
) (
  // Clock, power-up reset, clock enable
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Reset request pins, active low
  input wire logic reset_input_fast_n_in,
  input wire logic reset_input_slow_n_in,
  // Analog comparator results from pins
  input wire logic supply_ok_in,
  input wire logic power_fail_sense_in,
  input wire logic battery_ok_in,
  // Events from the timekeeping and interrupt logic
  input wire logic century_rollover_in,
  input wire logic irq_request_in,
  // Host write and read
  input wire logic wr_en_in,
  input wire logic [5:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [5:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  output logic wr_reject_out,
  // Reset and flag pins
  output logic reset_n_out,
  output logic power_fail_flag_pin_out,
  output logic irq_multi_pin_out,
  output logic irq_multi_pin_oe_out,
  // Control and status bits
  output logic deselected_out,
  output logic century_toggle_enable_out,
  output logic century_flag_out,
  output logic deselect_time_short_out,
  output logic osc_halt_flag_out,
  output logic halt_update_bit_out,
  output logic out_level_out,
  output logic freq_test_enable_out,
  output logic alarm_irq_enable_out,
  output logic backup_alarm_enable_out,
  output logic square_wave_enable_out,
  output logic [7:0] watchdog_out,
  output logic battery_low_flag_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Hold length decode, shared by both hold timers
  function automatic logic [CNT_W-1:0] trec_len(input logic tr,
                                                input logic st);
    logic [CNT_W-1:0] len;
    if (tr) begin
      len = CNT_W'(`RPS_TREC_SHORT_CYC); // R16
    end else if (st) begin
      len = CNT_W'(TREC_DEF_CYC); // R16
    end else begin
      len = CNT_W'(TREC_MID_CYC); // R16
    end
    return len;
  endfunction : trec_len

  // Register byte as the host sees it; unused bits read zero
  function automatic logic [7:0] reg_byte(input logic [5:0] addr,
                                          input rps_pkg::rps_top_state_t s);
    logic [7:0] b;
    b = 8'h00;
    case (addr)
      `RPS_ADDR_STOP: begin
        b[`RPS_BIT_ST] = s.st;
      end
      `RPS_ADDR_CENT: begin
        b[`RPS_BIT_CEB] = s.ceb;
        b[`RPS_BIT_CB] = s.cb;
      end
      `RPS_ADDR_TREC: begin
        b[`RPS_BIT_TR] = s.tr;
      end
      `RPS_ADDR_CTRL: begin
        b[`RPS_BIT_OUT] = s.out;
        b[`RPS_BIT_FT] = s.ft;
      end
      `RPS_ADDR_WDOG: begin
        b = s.wd;
      end
      `RPS_ADDR_ALRM: begin
        b[`RPS_BIT_AFE] = s.afe;
        b[`RPS_BIT_SQUARE_WAVE_ENABLE] = s.square_wave_enable;
        b[`RPS_BIT_ABE] = s.abe;
      end
      `RPS_ADDR_HALT: begin
        b[`RPS_BIT_HT] = s.ht;
      end
      `RPS_ADDR_FLAG: begin
        b[`RPS_BIT_BL] = s.bl;
      end
      default: begin
        b = 8'h00;
      end
    endcase
    return b;
  endfunction : reg_byte

  ////////////////////////////////////////////////////////////////////////////
  // Reset request qualification
  logic fast_req;
  logic slow_req;

  rps_glitch_filter #(
    .CNT_W(CNT_W),
    .MIN_CYC(`RPS_FAST_CYC)
  ) u_fast_filter (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .pin_n_in(reset_input_fast_n_in), // R2
    .req_out(fast_req)
  );

  // Threshold at the reject time so every 100ms hold is caught
  rps_glitch_filter #(
    .CNT_W(CNT_W),
    .MIN_CYC(SLOW_CYC)
  ) u_slow_filter (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .pin_n_in(reset_input_slow_n_in), // R3
    .req_out(slow_req)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Hold timers: one for power recovery, one for reset requests
  rps_pkg::rps_top_state_t s_q;
  rps_pkg::rps_top_state_t s_d;
  logic bat_test;
  logic out_mode;

  rps_hold_if #(.W(CNT_W)) pw_if ();
  rps_hold_if #(.W(CNT_W)) rs_if ();

  assign pw_if.cause = (s_q.pwr == rps_pkg::PS_BACKUP); // R20
  assign pw_if.len = trec_len(s_q.tr, s_q.st); // R15
  assign rs_if.cause = fast_req | slow_req; // R1
  assign rs_if.len = trec_len(s_q.tr, s_q.st); // R4

  rps_hold_timer #(
    .W(CNT_W)
  ) u_pwr_hold (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .hold(pw_if)
  );

  rps_hold_timer #(
    .W(CNT_W)
  ) u_rst_hold (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .hold(rs_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    bat_test = 1'b0;
    s_d.sup_meta = supply_ok_in;
    s_d.sup_sync = s_q.sup_meta;
    s_d.sns_meta = power_fail_sense_in;
    s_d.sns_sync = s_q.sns_meta;
    s_d.bat_meta = battery_ok_in;
    s_d.bat_sync = s_q.bat_meta;
    s_d.wr_rej = 1'b0;

    // Power sequencing
    case (s_q.pwr)
      rps_pkg::PS_BACKUP: begin
        if (s_q.sup_sync) begin
          s_d.pwr = rps_pkg::PS_RECOVER;
          s_d.ht = 1'b1; // R19
          s_d.ft = 1'b0; // R19
          s_d.afe = 1'b0; // R19
          s_d.abe = 1'b0; // R19
          s_d.square_wave_enable = 1'b0; // R19
          s_d.wd = 8'h00; // R19
          s_d.bat_cnt = '0;
          bat_test = 1'b1; // R11
        end
      end
      rps_pkg::PS_RECOVER: begin
        if (!s_q.sup_sync) begin
          s_d.pwr = rps_pkg::PS_BACKUP; // R20
        end else if (!pw_if.busy) begin
          s_d.pwr = rps_pkg::PS_RUN; // R7
        end
      end
      rps_pkg::PS_RUN: begin
        if (!s_q.sup_sync) begin
          s_d.pwr = rps_pkg::PS_BACKUP; // R6
        end
      end
      default: begin
        s_d.pwr = rps_pkg::PS_BACKUP;
      end
    endcase

    // Periodic battery check runs on main supply only
    if (s_q.pwr != rps_pkg::PS_BACKUP) begin // R14
      if (s_q.bat_cnt >= BAT_PERIOD_CYC - 1'b1) begin
        s_d.bat_cnt = '0;
        bat_test = 1'b1; // R11
      end else begin
        s_d.bat_cnt = s_q.bat_cnt + 1'b1;
      end
    end
    // Flag follows the latest test only, set or clear
    if (bat_test) begin
      s_d.bl = ~s_q.bat_sync; // R12 R13
    end

    // Host writes; refused until the recovery hold is over
    if (wr_en_in) begin
      if (s_q.pwr != rps_pkg::PS_RUN) begin
        s_d.wr_rej = 1'b1; // R17
      end else begin
        case (wr_addr_in)
          `RPS_ADDR_STOP: begin
            s_d.st = wr_data_in[`RPS_BIT_ST];
          end
          `RPS_ADDR_CENT: begin
            s_d.ceb = wr_data_in[`RPS_BIT_CEB]; // R8
            s_d.cb = wr_data_in[`RPS_BIT_CB]; // R8
          end
          `RPS_ADDR_TREC: begin
            s_d.tr = wr_data_in[`RPS_BIT_TR]; // R15
          end
          `RPS_ADDR_CTRL: begin
            s_d.out = wr_data_in[`RPS_BIT_OUT];
            s_d.ft = wr_data_in[`RPS_BIT_FT];
          end
          `RPS_ADDR_WDOG: begin
            s_d.wd = wr_data_in;
          end
          `RPS_ADDR_ALRM: begin
            s_d.afe = wr_data_in[`RPS_BIT_AFE];
            s_d.square_wave_enable = wr_data_in[`RPS_BIT_SQUARE_WAVE_ENABLE];
            s_d.abe = wr_data_in[`RPS_BIT_ABE];
          end
          `RPS_ADDR_HALT: begin
            s_d.ht = wr_data_in[`RPS_BIT_HT];
          end
          default: begin
            s_d.wr_rej = 1'b0;
          end
        endcase
      end
    end

    // Rollover applied after a same-cycle write, so it is never lost
    if (century_rollover_in && s_d.ceb) begin
      s_d.cb = ~s_d.cb; // R8
    end

    // Reset output: any cause holds it, the latest release ends it
    s_d.rst_n = (s_d.pwr == rps_pkg::PS_RUN) && !rs_if.cause &&
                !rs_if.busy; // R21 R20 R4

    // Power-fail flag pin
    case (s_d.pwr)
      rps_pkg::PS_BACKUP: begin
        s_d.power_fail_flag_pin = 1'b0; // R6
      end
      rps_pkg::PS_RECOVER: begin
        s_d.power_fail_flag_pin = 1'b1; // R7
      end
      rps_pkg::PS_RUN: begin
        s_d.power_fail_flag_pin = s_q.sns_sync; // R5
      end
      default: begin
        s_d.power_fail_flag_pin = 1'b0;
      end
    endcase

    // Shared interrupt pin: output mode when the others are idle
    out_mode = !s_d.ft && !s_d.afe && (s_d.wd == 8'h00);
    if (out_mode) begin
      s_d.irq_oe = !s_d.out; // R9
    end else begin
      s_d.irq_oe = irq_request_in;
    end

    s_d.rd_data = reg_byte(rd_addr_in, s_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset stands for the first power application
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.pwr <= rps_pkg::PS_BACKUP;
      s_q.st <= `RPS_INIT_ST; // R18
      s_q.out <= `RPS_INIT_OUT; // R18
      s_q.ht <= `RPS_INIT_HT; // R18
      s_q.tr <= `RPS_INIT_TR; // R18
      s_q.wd <= `RPS_INIT_WDOG; // R18
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reset_n_out = s_q.rst_n;
  assign power_fail_flag_pin_out = s_q.power_fail_flag_pin;
  // Pin is never driven high; the pull-up makes the high level
  assign irq_multi_pin_out = 1'b0; // R10
  assign irq_multi_pin_oe_out = s_q.irq_oe; // R10
  assign wr_reject_out = s_q.wr_rej;
  assign rd_data_out = s_q.rd_data;
  assign deselected_out = (s_q.pwr != rps_pkg::PS_RUN);
  assign century_toggle_enable_out = s_q.ceb;
  assign century_flag_out = s_q.cb;
  assign deselect_time_short_out = s_q.tr;
  assign osc_halt_flag_out = s_q.st;
  assign halt_update_bit_out = s_q.ht;
  assign out_level_out = s_q.out;
  assign freq_test_enable_out = s_q.ft;
  assign alarm_irq_enable_out = s_q.afe;
  assign backup_alarm_enable_out = s_q.abe;
  assign square_wave_enable_out = s_q.square_wave_enable;
  assign watchdog_out = s_q.wd;
  assign battery_low_flag_out = s_q.bl;

endmodule : rps_supervisor

/* tb/rps_supervisor_monitor.sv */
module rps_supervisor_monitor #(
  parameter int unsigned TREC_MID_CYC = 30,
  parameter int unsigned TREC_DEF_CYC = 20
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Pins and strobes
  input wire logic reset_input_fast_n_in,
  input wire logic reset_input_slow_n_in,
  input wire logic supply_ok_in,
  input wire logic power_fail_sense_in,
  input wire logic century_rollover_in,
  input wire logic wr_en_in,
  // Outputs
  input wire logic wr_reject_out,
  input wire logic reset_n_out,
  input wire logic power_fail_flag_pin_out,
  input wire logic irq_multi_pin_out,
  input wire logic irq_multi_pin_oe_out,
  input wire logic deselected_out,
  input wire logic century_toggle_enable_out,
  input wire logic century_flag_out,
  input wire logic deselect_time_short_out,
  input wire logic osc_halt_flag_out,
  input wire logic halt_update_bit_out,
  input wire logic out_level_out,
  input wire logic freq_test_enable_out,
  input wire logic alarm_irq_enable_out,
  input wire logic backup_alarm_enable_out,
  input wire logic square_wave_enable_out,
  input wire logic [7:0] watchdog_out
);
  // Cycles since every reset cause went away; raw pins, so a few
  // cycles of synchroniser slack are allowed above the hold time
  logic [15:0] calm_q;
  logic [15:0] calm_d;
  logic irq_idle;
  int unsigned hold;
  assign irq_idle = !freq_test_enable_out && !alarm_irq_enable_out &&
    watchdog_out == 8'h00;
  assign hold = deselect_time_short_out ? 500 :
    (osc_halt_flag_out ? TREC_DEF_CYC : TREC_MID_CYC);
  always_comb begin
    calm_d = calm_q;
    if (!(reset_input_fast_n_in && reset_input_slow_n_in && supply_ok_in))
      calm_d = 16'h0000;
    else if (calm_q != 16'hFFFF)
      calm_d = calm_q + 16'h0001;
  end
  always_ff @(posedge core_clk_in) begin
    if (reset_in)
      calm_q <= 16'h0000;
    else
      calm_q <= calm_d;
  end
  default clocking mon_clk @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////////////
  AST_REJECT: assert property (
    wr_en_in && ce_in && deselected_out |=> wr_reject_out)
    else $error("write taken while deselected");
  AST_BACKUP: assert property (
    !supply_ok_in [*5] |-> !power_fail_flag_pin_out && !reset_n_out)
    else $error("flag or reset not low in back-up");
  AST_RECOVER: assert property (
    $rose(supply_ok_in) ##1 supply_ok_in [*5] |-> power_fail_flag_pin_out)
    else $error("flag not forced high in recovery");
  AST_SENSE: assert property (
    (!deselected_out && $stable(power_fail_sense_in)) [*5] |->
    power_fail_flag_pin_out == power_fail_sense_in)
    else $error("flag does not follow sense");
  AST_DEFAULTS: assert property (
    $fell(reset_in) |-> osc_halt_flag_out && out_level_out &&
    halt_update_bit_out && !deselect_time_short_out && irq_idle &&
    !backup_alarm_enable_out && !square_wave_enable_out)
    else $error("wrong first power defaults");
  AST_IRQ_MODE: assert property (
    irq_idle && $past(irq_idle) && $stable(out_level_out) |->
    irq_multi_pin_oe_out == !out_level_out)
    else $error("pin does not show output bit");
  AST_OPEN_DRAIN: assert property (
    irq_multi_pin_out == 1'h0)
    else $error("pin driven high");
  AST_CENTURY: assert property (
    century_rollover_in && ce_in && !wr_en_in |=> century_flag_out ==
    ($past(century_flag_out) ^ $past(century_toggle_enable_out)))
    else $error("century flag wrong after rollover");
  AST_FAST: assert property (
    !reset_input_fast_n_in [*8] |-> !reset_n_out)
    else $error("fast request gave no reset");
  AST_HOLD_MIN: assert property (
    $rose(reset_n_out) |-> calm_q >= hold)
    else $error("reset released before hold time");
  AST_HOLD_MAX: assert property (
    reset_n_out || calm_q <= hold + 12)
    else $error("reset held too long");
endmodule : rps_supervisor_monitor

bind rps_supervisor rps_supervisor_monitor #(
  .TREC_MID_CYC(TREC_MID_CYC), .TREC_DEF_CYC(TREC_DEF_CYC)
) i_rps_supervisor_monitor (.*);

/* tb/rps_host_model.sv */
module rps_host_model (
  // Clock
  input wire logic core_clk_in,
  // Pins toward the supervisor
  output logic fast_n_out,
  output logic slow_n_out,
  output logic supply_ok_out,
  output logic sense_out,
  output logic battery_ok_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Reset pins idle high through their pull-ups
  initial begin
    fast_n_out = 1'h1;
    slow_n_out = 1'h1;
    supply_ok_out = 1'h0;
    sense_out = 1'h0;
    battery_ok_out = 1'h0;
  end
  // Short pulses are commanded on purpose to probe rejection
  task automatic pulse_pin(input logic slow, input int n);
    @(negedge core_clk_in);
    if (slow)
      slow_n_out = 1'h0;
    else
      fast_n_out = 1'h0;
    repeat (n) @(negedge core_clk_in);
    slow_n_out = 1'h1;
    fast_n_out = 1'h1;
  endtask : pulse_pin
  task automatic set_levels(input logic sup, input logic sns,
                            input logic bat);
    @(negedge core_clk_in);
    supply_ok_out = sup;
    sense_out = sns;
    battery_ok_out = bat;
  endtask : set_levels
endmodule : rps_host_model

/* tb/rps_supervisor_test.sv */
module rps_supervisor_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MID = 30;
  localparam int DEF = 20;
  logic clk = 1'h0;
  logic reset_in = 1'h1;
  logic wr_en = 1'h0;
  logic [5:0] wr_addr = 6'h00;
  logic [7:0] wr_data = 8'h00;
  logic [5:0] rd_addr = 6'h00;
  logic roll_in = 1'h0;
  logic irq_req = 1'h0;
  logic fast_n, slow_n, sup_ok, sense, bat_ok, rej;
  logic [7:0] rd_data, wd;
  logic wr_rej, rst_n, power_fail_flag_pin, pin, oe, desel, ceb, cb, tr, st, ht, out;
  logic ft, afe, abe, square_wave_enable, bl;
  int miscompares = 0;
  int n_checks = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  rps_host_model i_rps_host_model (.core_clk_in(clk), .fast_n_out(fast_n),
    .slow_n_out(slow_n), .supply_ok_out(sup_ok), .sense_out(sense),
    .battery_ok_out(bat_ok));
  rps_supervisor #(.SLOW_CYC(20), .TREC_MID_CYC(MID), .TREC_DEF_CYC(DEF),
    .BAT_PERIOD_CYC(40'h64)) i_rps_supervisor (.core_clk_in(clk),
    .reset_in(reset_in), .ce_in(1'h1), .reset_input_fast_n_in(fast_n),
    .reset_input_slow_n_in(slow_n), .supply_ok_in(sup_ok),
    .power_fail_sense_in(sense), .battery_ok_in(bat_ok),
    .century_rollover_in(roll_in), .irq_request_in(irq_req),
    .wr_en_in(wr_en), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
    .rd_addr_in(rd_addr), .rd_data_out(rd_data), .wr_reject_out(wr_rej),
    .reset_n_out(rst_n), .power_fail_flag_pin_out(power_fail_flag_pin),
    .irq_multi_pin_out(pin), .irq_multi_pin_oe_out(oe),
    .deselected_out(desel), .century_toggle_enable_out(ceb),
    .century_flag_out(cb), .deselect_time_short_out(tr),
    .osc_halt_flag_out(st), .halt_update_bit_out(ht), .out_level_out(out),
    .freq_test_enable_out(ft), .alarm_irq_enable_out(afe),
    .backup_alarm_enable_out(abe), .square_wave_enable_out(square_wave_enable),
    .watchdog_out(wd), .battery_low_flag_out(bl));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // Reject pulse stands one cycle, so it is read at the next fall
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'h1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    rej = wr_rej;
    wr_en = 1'h0;
  endtask : wr
  task automatic wait_release(input int lo);
    int n;
    n = 0;
    while (rst_n !== 1'h1 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(32'(n >= lo && n <= lo + 12), 32'h1);
    if (rst_n !== 1'h1) begin
      report_and_stop();
    end
  endtask : wait_release
  task automatic roll();
    @(negedge clk);
    roll_in = 1'h1;
    @(negedge clk);
    roll_in = 1'h0;
  endtask : roll
  ////////////////////////////////////////////////////////////////////////
  task automatic t_power_up();
    check({st, out, ht, tr, ft, afe, abe, square_wave_enable, wd}, 16'hE000);
    check({rst_n, power_fail_flag_pin}, 2'h0);
    i_rps_host_model.set_levels(1'h1, 1'h0, 1'h0);
    repeat (8) @(negedge clk);
    check(power_fail_flag_pin, 1'h1);
    wr(6'h03, 8'hC0);
    check({rej, ceb}, 2'h2);
    wait_release(DEF - 10);
    repeat (5) @(negedge clk);
    check({power_fail_flag_pin, bl}, 2'h1);
    i_rps_host_model.set_levels(1'h1, 1'h1, 1'h0);
    repeat (5) @(negedge clk);
    check(power_fail_flag_pin, 1'h1);
    $display("done power_up");
  endtask : t_power_up
  task automatic t_century();
    wr(6'h03, 8'hC0);
    check({rej, ceb, cb}, 3'h3);
    roll();
    check(cb, 1'h0);
    wr(6'h03, 8'h40);
    roll();
    check({ceb, cb}, 2'h1);
    rd_addr = 6'h03;
    repeat (2) @(negedge clk);
    check(rd_data & 8'hC0, 8'h40);
    $display("done century");
  endtask : t_century
  task automatic t_battery();
    int n;
    i_rps_host_model.set_levels(1'h1, 1'h1, 1'h1);
    repeat (3) @(negedge clk);
    check(bl, 1'h1);
    n = 0;
    while (bl !== 1'h0 && n < 120) begin
      @(negedge clk);
      n++;
    end
    check(32'(n <= 100), 32'h1);
    if (bl !== 1'h0) begin
      report_and_stop();
    end
    $display("done battery");
  endtask : t_battery
  task automatic t_irq();
    wr(6'h08, 8'h00);
    repeat (2) @(negedge clk);
    check({oe, pin}, 2'h2);
    wr(6'h08, 8'h80);
    repeat (2) @(negedge clk);
    check(oe, 1'h0);
    // Frequency test on: the pin leaves output mode
    wr(6'h08, 8'h40);
    irq_req = 1'h1;
    repeat (2) @(negedge clk);
    check(oe, 1'h1);
    irq_req = 1'h0;
    repeat (2) @(negedge clk);
    check(oe, 1'h0);
    wr(6'h08, 8'h80);
    $display("done irq");
  endtask : t_irq
  task automatic t_reset_pins();
    // Fast 1 and 8 cycles, slow 10 and 30 cycles
    for (int k = 0; k < 4; k++) begin
      i_rps_host_model.pulse_pin(k[1], k[0] ? (k[1] ? 30 : 8) :
                                 (k[1] ? 10 : 1));
      if (k[0]) begin
        check(rst_n, 1'h0);
        wait_release(DEF);
      end else begin
        repeat (30) @(negedge clk);
        check(rst_n, 1'h1);
      end
    end
    $display("done reset_pins");
  endtask : t_reset_pins
  task automatic t_hold_table();
    logic [7:0] sel [3] = '{8'h80, 8'h00, 8'h00};
    logic [7:0] stp [3] = '{8'h80, 8'h00, 8'h80};
    int len [3] = '{500, MID, DEF};
    for (int k = 0; k < 3; k++) begin
      wr(6'h04, sel[k]);
      wr(6'h01, stp[k]);
      check({tr, st}, {sel[k][7], stp[k][7]});
      i_rps_host_model.pulse_pin(1'h0, 8);
      wait_release(len[k]);
    end
    $display("done hold_table");
  endtask : t_hold_table
  task automatic t_later_power();
    wr(6'h08, 8'h40);
    wr(6'h0A, 8'hE0);
    wr(6'h09, 8'h55);
    wr(6'h0C, 8'h00);
    check({out, ht, ft, afe, abe, square_wave_enable, wd}, 14'h0F55);
    i_rps_host_model.set_levels(1'h0, 1'h1, 1'h1);
    repeat (6) @(negedge clk);
    check({rst_n, power_fail_flag_pin, desel}, 3'h1);
    wr(6'h03, 8'h80);
    check(rej, 1'h1);
    i_rps_host_model.set_levels(1'h0, 1'h1, 1'h0);
    repeat (150) @(negedge clk);
    check(bl, 1'h0);
    i_rps_host_model.set_levels(1'h1, 1'h1, 1'h0);
    wait_release(DEF);
    check({st, out, ht, tr, ft, afe, abe, square_wave_enable, wd}, 16'hA000);
    check({bl, oe}, 2'h3);
    $display("done later_power");
  endtask : t_later_power
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk);
    reset_in = 1'h0;
    t_power_up();
    t_century();
    t_battery();
    t_irq();
    t_reset_pins();
    t_hold_table();
    t_later_power();
    report_and_stop();
  end
endmodule : rps_supervisor_test
